// ==== src/random_word_source.sv ====
// Random word source: AHB-lite slave around a free-running noise sampler
`include "rng_defs.svh"

module random_word_source #(
  parameter int unsigned PERIOD_CYC = `RNG_PERIOD_CYC  // Least cycles between fresh words
) (
  input  wire logic             i_ref_clk,    // 250 MHz bus clock
  input  wire logic             i_nrst,       // Async reset, active low
  input  wire rng_pkg::ahb_req_t i_req,       // AHB address phase
  input  wire logic [31:0]      i_hwdata,     // AHB write data
  input  wire logic             i_noise,      // Raw analog noise comparator output
  output logic [31:0]           o_hrdata,     // AHB read data
  output logic                  o_hreadyout,  // AHB ready out
  output logic                  o_hresp,      // AHB response
  output logic                  o_osc_pd,     // Noise oscillator power-down
  output logic                  o_gen_clk_en  // Generator clock gate enable
);
  import rng_pkg::*;

  // Elaboration check: a word needs sixteen folded noise bits
  if (PERIOD_CYC < 16) begin : g_bad_period
    $error("PERIOD_CYC must cover sixteen noise bits");
  end

  localparam int CW = $clog2(PERIOD_CYC + 1);

  // ------------------------------------------------------------
  // Noise input synchroniser
  // ------------------------------------------------------------
  logic [2:0] noise_sync_reg;
  logic       noise_reg;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      noise_sync_reg <= 3'h0;
    end else begin
      noise_sync_reg <= {noise_sync_reg[1:0], i_noise};
    end
  end

  // Change counts only when second and third stage agree
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      noise_reg <= 1'b0;
    end else if (noise_sync_reg[1] == noise_sync_reg[2]) begin
      noise_reg <= noise_sync_reg[2];
    end
  end

  // ------------------------------------------------------------
  // Bus address phase capture
  // ------------------------------------------------------------
  bus_state_t  state_reg;
  logic        ctrl_off_reg;
  logic        ready_reg;
  logic [15:0] word_reg;
  logic [15:0] shift_reg;
  logic [CW-1:0] cnt_reg;
  logic        word_done;
  logic        acc_valid;
  logic        acc_full;
  logic        dp_write_reg;
  logic        dp_ctrl_reg;
  logic        dp_read_out_reg;

  assign acc_valid = i_req.sel && i_req.ready && i_req.trans[1];
  assign acc_full  = (i_req.size == `RNG_SIZE_WORD);
  assign word_done = !ctrl_off_reg && (cnt_reg == CW'(PERIOD_CYC - 1));

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  logic [31:0] ctrl_write;
  assign ctrl_write = i_hwdata;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_off_reg <= 1'b0;
    end else if (dp_write_reg && dp_ctrl_reg) begin
      ctrl_off_reg <= ctrl_write[`RNG_OFF_BIT];
    end
  end

  // Gate and power-down follow the stored bit one cycle later
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_osc_pd     <= 1'b0;
      o_gen_clk_en <= 1'b1;
    end else begin
      o_osc_pd     <= ctrl_off_reg;
      o_gen_clk_en <= !ctrl_off_reg;
    end
  end

  // ------------------------------------------------------------
  // Noise gathering
  // ------------------------------------------------------------
  // The period counter paces words so no two are closer than the minimum
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= '0;
    end else if (ctrl_off_reg) begin
      cnt_reg <= '0;
    end else if (word_done) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  // Each enabled cycle folds one noise bit into the running word
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_reg <= 16'h0000;
    end else if (!ctrl_off_reg) begin
      shift_reg <= {shift_reg[14:0], shift_reg[15] ^ noise_reg};
    end
  end

  // New word replaces the old only when nobody holds the old one
  logic read_done;
  assign read_done = (state_reg == ST_WAIT) && ready_reg;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      word_reg <= 16'h0000;
    end else if (word_done && (!ready_reg || read_done)) begin
      word_reg <= shift_reg;
    end
  end

  // Ready: set by a gathered word, cleared by a finished read
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ready_reg <= 1'b0;
    end else if (ctrl_off_reg) begin
      ready_reg <= 1'b0;
    end else if (word_done) begin
      ready_reg <= 1'b1;
    end else if (read_done) begin
      ready_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dp_write_reg    <= 1'b0;
      dp_ctrl_reg     <= 1'b0;
      dp_read_out_reg <= 1'b0;
    end else begin
      dp_write_reg    <= acc_valid && acc_full && i_req.write;
      dp_ctrl_reg     <= (i_req.addr == `RNG_OFS_CONTROL);
      dp_read_out_reg <= acc_valid && acc_full && !i_req.write && (i_req.addr == `RNG_OFS_OUTPUT);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg   <= ST_IDLE;
      o_hreadyout <= 1'b1;
      o_hresp     <= `RNG_HRESP_OKAY;
      o_hrdata    <= 32'h0000_0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          o_hresp  <= `RNG_HRESP_OKAY;
          o_hrdata <= 32'h0000_0000;
          if (acc_valid && !acc_full) begin
            o_hreadyout <= 1'b0;
            o_hresp     <= `RNG_HRESP_ERROR;
            state_reg   <= ST_ERR2;
          end else if (acc_valid && !i_req.write) begin
            if (i_req.addr == `RNG_OFS_CONTROL) begin
              o_hrdata[`RNG_OFF_BIT] <= ctrl_off_reg;
            end else if (i_req.addr == `RNG_OFS_FLAGS) begin
              o_hrdata[`RNG_RDY_BIT] <= ready_reg;
            end else if (i_req.addr == `RNG_OFS_OUTPUT) begin
              o_hreadyout <= 1'b0;
              state_reg   <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (ctrl_off_reg) begin
            // Disabled generator can never deliver; finish with zero
            o_hreadyout <= 1'b1;
            state_reg   <= ST_IDLE;
          end else if (ready_reg) begin
            o_hrdata    <= {16'h0000, word_reg};
            o_hreadyout <= 1'b1;
            state_reg   <= ST_IDLE;
          end
        end
        ST_ERR2: begin
          o_hreadyout <= 1'b1;
          state_reg   <= ST_IDLE;
        end
        default: begin
          state_reg   <= ST_IDLE;
          o_hreadyout <= 1'b1;
        end
      endcase
    end
  end
endmodule : random_word_source

// ==== pkg/rng_defs.svh ====
// Constants for the random word source: offsets, fields, reset values, timing
// Functional notes
// - Host may read the output register any time, no trigger needed.
// - Only full 32-bit accesses are legal; narrower ones get an error response.
// - Fresh words arrive no faster than one per 1.25 us.
// - Control bit 2 at 0 runs the generator; at 1 disables it.
// - Disabled: noise oscillators powered down and generator clock gated.
// - Output read while enabled with flag bit 0 at 0 waits until a word arrives; while disabled it returns zero at once (code: after one wait state).
// - Flag bit 0 is 1 exactly when the output register holds a valid word.
// - Ready flag stays 0 while the generator is disabled.
// - Word sits in bits 15:0; bits 31:16 read zero.
// - Control, flags, output at 0x00, 0x04, 0x08; reset zero; only control writable.
`ifndef RNG_DEFS_SVH
`define RNG_DEFS_SVH
`define RNG_OFS_CONTROL   12'h000
`define RNG_OFS_FLAGS     12'h004
`define RNG_OFS_OUTPUT    12'h008
`define RNG_OFF_BIT       2
`define RNG_RDY_BIT       0
`define RNG_WORD_W        16
`define RNG_CTRL_RESET    32'h0000_0000
`define RNG_SIZE_WORD     3'h2
`define RNG_HTRANS_NSEQ   2'h2
`define RNG_HRESP_OKAY    1'b0
`define RNG_HRESP_ERROR   1'b1
`define RNG_CLK_MHZ       250
`define RNG_PERIOD_NS     1250
`define RNG_PERIOD_CYC    ((`RNG_PERIOD_NS * `RNG_CLK_MHZ + 999) / 1000)
`endif

// ==== pkg/rng_pkg.sv ====
// Types shared by the random word source
package rng_pkg;
  typedef struct packed {
    logic        sel;    // Slave selected
    logic [1:0]  trans;  // Transfer type
    logic        write;  // Write transfer
    logic [2:0]  size;   // Transfer size
    logic [11:0] addr;   // Byte offset inside the block
    logic        ready;  // Bus ready in
  } ahb_req_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_ERR2  = 3'b100
  } bus_state_t;
endpackage : rng_pkg

// ==== tb/rng_monitor.sv ====
// Port checker for the random word source
module rng_monitor
  import rng_pkg::*;
#(parameter int unsigned PERIOD_CYC = 313) (
  input wire logic        i_ref_clk,
  input wire logic        i_nrst,
  input wire ahb_req_t    i_req,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_noise,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_osc_pd,
  input wire logic        o_gen_clk_en
);
  localparam int MAXW = PERIOD_CYC + 8;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  wire  tk  = i_req.sel & i_req.ready & i_req.trans[1];
  wire  rdw = tk & !i_req.write & (i_req.size == 3'h2);
  logic dp_out_reg, dp_flag_reg;
  // Data phase tracking; a new address only lands once the previous answer is out
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) {dp_out_reg, dp_flag_reg} <= 2'h0;
    else if (tk) {dp_out_reg, dp_flag_reg} <= {rdw & (i_req.addr == 12'h008), rdw & (i_req.addr == 12'h004)};
    else if (o_hreadyout) {dp_out_reg, dp_flag_reg} <= 2'h0;
  end
  gate_pair_a: assert property (o_gen_clk_en == !o_osc_pd)
    else $error("clock gate and power-down disagree");
  ctrl_write_a: assert property (tk & i_req.write & i_req.addr == 12'h000 & i_req.size == 3'h2
    |-> ##3 o_osc_pd == $past(i_hwdata[2], 2)) else $error("power-down does not follow control");
  narrow_err_a: assert property (tk & i_req.size != 3'h2 |=> !o_hreadyout & o_hresp ##1 o_hreadyout & o_hresp)
    else $error("narrow access without error response");
  word_ok_a: assert property (tk & i_req.size == 3'h2 |=> !o_hresp)
    else $error("word access answered with error");
  reg_fast_a: assert property (rdw & i_req.addr != 12'h008 |=> o_hreadyout)
    else $error("register read stalled");
  out_wait_a: assert property (rdw & i_req.addr == 12'h008 |=> !o_hreadyout ##[1:MAXW] o_hreadyout)
    else $error("output read wait wrong");
  upper_zero_a: assert property (dp_out_reg & o_hreadyout |-> o_hrdata[31:16] == 16'h0)
    else $error("reserved output bits not zero");
  off_flag_a: assert property (dp_flag_reg & o_hreadyout & o_osc_pd & $past(o_osc_pd) |-> o_hrdata == 32'h0)
    else $error("ready flag set while disabled");
  cover property (rdw & i_req.addr == 12'h008 ##1 !o_hreadyout [*3]);
  cover property (tk & i_req.size != 3'h2);
  cover property ($rose(o_osc_pd));
endmodule : rng_monitor
bind random_word_source rng_monitor #(.PERIOD_CYC(PERIOD_CYC)) mon (.i_ref_clk, .i_nrst, .i_req, .i_hwdata,
  .i_noise, .o_hrdata, .o_hreadyout, .o_hresp, .o_osc_pd, .o_gen_clk_en);

// ==== tb/host_model.sv ====
// Host processor model issuing single bus transfers
module host_model (
  input  wire logic        i_ref_clk,  // Bus clock
  input  wire logic        i_hready,   // Ready from the slave
  input  wire logic        i_hresp,    // Response from the slave
  input  wire logic [31:0] i_hrdata,   // Read data from the slave
  output rng_pkg::ahb_req_t o_req,     // Address phase
  output logic [31:0]      o_hwdata    // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  import rng_pkg::*;
  logic        sel = 1'b0;
  logic        wr  = 1'b0;
  logic [2:0]  sz  = 3'h2;
  logic [11:0] adr = 12'h0;
  initial o_hwdata = 32'h0;
  assign o_req = {sel, sel ? 2'h2 : 2'h0, wr, sz, adr, i_hready};
  // Released lines flip so a stale value never looks valid
  task automatic xfer(input logic w, input logic [11:0] a, input logic [2:0] s, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output int cyc);
    @(negedge i_ref_clk);
    {sel, wr, sz, adr} = {1'b1, w, s, a};
    o_hwdata = ~o_hwdata;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    {sel, adr} = {1'b0, ~a};
    o_hwdata = d;
    cyc = 0;
    do begin @(posedge i_ref_clk); cyc++; end while (!i_hready && cyc < 2000);
    {r, e} = {i_hrdata, i_hresp};
  endtask : xfer
endmodule : host_model

// ==== tb/random_word_source_tb_top.sv ====
// Self-checking bench for the random word source
`include "rng_defs.svh"
module random_word_source_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rng_pkg::*;
  localparam int unsigned PER = 40;
  logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_noise = 1'b0, hready, hresp, osc_pd, clk_en, e;
  ahb_req_t req;
  logic [31:0] hwdata, hrdata, r;
  int failures = 0, n_compared = 0, seed = 19265, ctrl_m = 0, cyc;
  time t0;
  random_word_source #(.PERIOD_CYC(PER)) dut (.i_ref_clk, .i_nrst, .i_req(req), .i_hwdata(hwdata), .i_noise,
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .o_osc_pd(osc_pd), .o_gen_clk_en(clk_en));
  host_model host (.i_ref_clk, .i_hready(hready), .i_hresp(hresp), .i_hrdata(hrdata), .o_req(req), .o_hwdata(hwdata));
  initial forever #2 i_ref_clk = ~i_ref_clk;
  always @(negedge i_ref_clk) i_noise <= ($random(seed) & 1) != 0;
  task automatic final_report();
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin failures++; $display("[ERR] %s exp %h got %h", n, x, g); end
  endtask : chk
  task automatic acc(input logic w, input logic [11:0] a, input logic [2:0] s, input logic [31:0] d);
    host.xfer(w, a, s, d, r, e, cyc);
    if (cyc >= 2000) begin failures++; final_report(); end
  endtask : acc
  initial begin
    repeat (8) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    acc(0, `RNG_OFS_CONTROL, `RNG_SIZE_WORD, 0);
    chk("control", 32'h0, r);
    acc(0, `RNG_OFS_FLAGS, `RNG_SIZE_WORD, 0);
    chk("flags", 32'h0, r);
    acc(0, `RNG_OFS_OUTPUT, `RNG_SIZE_WORD, 0);
    t0 = $time;
    chk("stalled", 32'h1, 32'(cyc > 1));
    chk("upper", 32'h0, r >> 16);
    acc(0, `RNG_OFS_FLAGS, `RNG_SIZE_WORD, 0);
    chk("cleared", 32'h0, r);
    acc(0, `RNG_OFS_OUTPUT, `RNG_SIZE_WORD, 0);
    chk("spacing", 32'h1, 32'(($time - t0) >= PER * 4));
    repeat (PER + 8) @(negedge i_ref_clk);
    acc(0, `RNG_OFS_FLAGS, `RNG_SIZE_WORD, 0);
    chk("ready", 32'h1, r);
    acc(0, `RNG_OFS_OUTPUT, `RNG_SIZE_WORD, 0);
    chk("prompt", 32'h2, cyc);
    for (int i = 0; i < 6; i++) begin
      acc(1'($random(seed)), 12'(4 * (i / 2)), 3'(i % 2), $random(seed));
      chk("resp", 32'h1, 32'(e));
    end
    acc(0, `RNG_OFS_CONTROL, `RNG_SIZE_WORD, 0);
    chk("control", 32'(ctrl_m), r);
    ctrl_m = 4;
    acc(1, `RNG_OFS_CONTROL, `RNG_SIZE_WORD, 32'(ctrl_m));
    repeat (4) @(negedge i_ref_clk);
    chk("pd", 32'h1, 32'(osc_pd));
    chk("clk_en", 32'h0, 32'(clk_en));
    acc(0, `RNG_OFS_CONTROL, `RNG_SIZE_WORD, 0);
    chk("control", 32'(ctrl_m), r);
    repeat (PER + 8) @(negedge i_ref_clk);
    acc(1, `RNG_OFS_FLAGS, `RNG_SIZE_WORD, 32'h1);
    acc(0, `RNG_OFS_FLAGS, `RNG_SIZE_WORD, 0);
    chk("off flag", 32'h0, r);
    acc(0, `RNG_OFS_OUTPUT, `RNG_SIZE_WORD, 0);
    chk("off word", 32'h0, r);
    acc(0, 12'h00c, `RNG_SIZE_WORD, 0);
    chk("unmapped", 32'h0, r);
    ctrl_m = 0;
    acc(1, `RNG_OFS_CONTROL, `RNG_SIZE_WORD, 32'(ctrl_m));
    repeat (PER + 8) @(negedge i_ref_clk);
    chk("pd", 32'h0, 32'(osc_pd));
    acc(0, `RNG_OFS_FLAGS, `RNG_SIZE_WORD, 0);
    chk("resume", 32'h1, r);
    final_report();
  end
endmodule : random_word_source_tb_top
